// *** rtl/src_clock_control.sv ***
/*
 * Reference clock and synthesizer control: startup sequencing, calibration,
 * reference clock output on auxiliary pin five, carrier frequency word and
 * a serial register port (mode 0, MSB first, address then data bytes).
 * Assumes CLK_SYS comes from the crystal oscillator; serial pins are async.
 */
// What this block does
// - Sequencer starts the synthesizer when the mode requests it, once the oscillator settles.
// - Reference clock output stays silent until the oscillator is stable.
// - Pin five carries reference divided by 2 to 128, chosen by select field.
// - Clock output works except in sleep, enabled after power-on reset.
// - Coarse oscillator calibration runs by itself after power-on reset.
// - Each synthesizer activation runs a fine calibration within wake-up time.
// - Synthesizer takes a 19-bit fractional part; step is reference over 2^19.
// - Carrier is step times 24-bit word at addresses 0x07 to 0x09.
// - Upper two bytes stay pending until the low byte is written.
// - With synthesizer on, first bit clock rising edge comes 120 us after wake.
`timescale 1ns/1ps
`include "src_regs.svh"

module src_clock_control
    import src_pkg::*;
#(
    parameter int OSC_SETTLE_CYC = `SRC_OSC_SETTLE_US * 1000 / `SRC_CLK_PERIOD_NS,
    parameter int TX_WAKE_CYC = `SRC_TX_WAKE_US * 1000 / `SRC_CLK_PERIOD_NS,
    parameter int BIT_HALF_CYC = 1000000000 / (`SRC_BIT_RATE_BPS * 2 * `SRC_CLK_PERIOD_NS)
)
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic SPI_NSS_N,
    input wire logic SPI_SCK,
    input wire logic SPI_MOSI,
    output logic SPI_MISO,
    output logic SPI_MISO_OE,
    output logic AUXILIARY_PIN_FIVE,
    output logic BIT_CLOCK_OUTPUT,
    output logic SYNTH_ENABLE,
    output logic COARSE_CAL_ACTIVE,
    output logic FINE_CAL_ACTIVE,
    output logic [23:0] CARRIER_FREQUENCY_WORD,
    output logic [4:0] SDM_INTEGER,
    output logic [`SRC_SDM_BITS-1:0] SDM_FRACTION
);

    localparam int COARSE_CYC = `SRC_COARSE_CAL_US * 1000 / `SRC_CLK_PERIOD_NS;
    localparam int FINE_CYC = `SRC_FINE_CAL_US * 1000 / `SRC_CLK_PERIOD_NS;

    // ------------------------------------------------------------------------
    // Serial pin synchronisers
    // ------------------------------------------------------------------------
    logic [2:0] nss_s_q, sck_s_q, mosi_s_q;
    logic nss_f_q, sck_f_q, mosi_f_q, sck_prev_q;
    logic sck_rise, sck_fall;

    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            nss_s_q <= 3'h7;
            sck_s_q <= 3'h0;
            mosi_s_q <= 3'h0;
            nss_f_q <= 1'b1;
            sck_f_q <= 1'b0;
            mosi_f_q <= 1'b0;
            sck_prev_q <= 1'b0;
        end else begin
            nss_s_q <= {nss_s_q[1:0], SPI_NSS_N};
            sck_s_q <= {sck_s_q[1:0], SPI_SCK};
            mosi_s_q <= {mosi_s_q[1:0], SPI_MOSI};
            if (nss_s_q[1] == nss_s_q[2]) nss_f_q <= nss_s_q[2];
            if (sck_s_q[1] == sck_s_q[2]) sck_f_q <= sck_s_q[2];
            if (mosi_s_q[1] == mosi_s_q[2]) mosi_f_q <= mosi_s_q[2];
            sck_prev_q <= sck_f_q;
        end
    end

    assign sck_rise = sck_f_q & ~sck_prev_q & ~nss_f_q;
    assign sck_fall = ~sck_f_q & sck_prev_q & ~nss_f_q;

    // ------------------------------------------------------------------------
    // Registers and read decode
    // ------------------------------------------------------------------------
    logic [7:0] mode_q, pin_map2_q, freq_hi_q, freq_mid_q, status;
    logic [23:0] freq_q;
    logic wr_q;
    logic [6:0] wr_addr_q;
    logic [7:0] wr_data_q;
    src_state_e state_q;
    logic osc_ok_q, coarse_ok_q;

    // Read value of a register; unmapped addresses read zero
    function automatic logic [7:0] reg_read(input logic [6:0] a);
        case (a)
            `SRC_ADDR_MODE: reg_read = mode_q;
            `SRC_ADDR_FREQ_HI: reg_read = freq_hi_q;
            `SRC_ADDR_FREQ_MID: reg_read = freq_mid_q;
            `SRC_ADDR_FREQ_LO: reg_read = freq_q[7:0];
            `SRC_ADDR_PIN_MAP2: reg_read = pin_map2_q;
            `SRC_ADDR_STATUS: reg_read = status;
            default: reg_read = 8'h00;
        endcase
    endfunction

    assign status = {3'h0, (state_q == ST_TX), (state_q == ST_FINE),
                     SYNTH_ENABLE & ~FINE_CAL_ACTIVE, coarse_ok_q, osc_ok_q};

    // ------------------------------------------------------------------------
    // Serial shifter: first byte is write flag and address, then data bytes
    // ------------------------------------------------------------------------
    logic [7:0] sh_q, sh_d, tx_q;
    logic [2:0] bit_q;
    logic first_q, wnr_q;
    logic [6:0] addr_q;

    assign sh_d = {sh_q[6:0], mosi_f_q};

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            bit_q <= 3'h0;
            first_q <= 1'b1;
            wnr_q <= 1'b0;
            addr_q <= 7'h00;
            wr_q <= 1'b0;
            wr_addr_q <= 7'h00;
            wr_data_q <= 8'h00;
            SPI_MISO <= 1'b0;
            SPI_MISO_OE <= 1'b0;
        end else begin
            wr_q <= 1'b0;
            SPI_MISO_OE <= ~nss_f_q;
            if (nss_f_q) begin
                bit_q <= 3'h0;
                first_q <= 1'b1;
            end else if (sck_rise) begin
                sh_q <= sh_d;
                bit_q <= bit_q + 3'h1;
                if (bit_q == 3'h7) begin
                    if (first_q) begin
                        first_q <= 1'b0;
                        wnr_q <= sh_d[7];
                        addr_q <= sh_d[6:0];
                        tx_q <= reg_read(sh_d[6:0]);
                    end else begin
                        wr_q <= wnr_q;
                        wr_addr_q <= addr_q;
                        wr_data_q <= sh_d;
                        addr_q <= addr_q + 7'h01;
                        tx_q <= reg_read(addr_q + 7'h01);
                    end
                end
            end else if (sck_fall) begin
                SPI_MISO <= tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // Mode and pin map registers; pin map resets with clock output on
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            mode_q <= `SRC_MODE_RESET;
            pin_map2_q <= `SRC_PIN_MAP2_RESET;
        end else if (wr_q) begin
            if (wr_addr_q == `SRC_ADDR_MODE) mode_q <= wr_data_q;
            if (wr_addr_q == `SRC_ADDR_PIN_MAP2) pin_map2_q <= wr_data_q;
        end
    end

    // Carrier word: upper bytes pend, low byte write commits all three
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            freq_hi_q <= 8'(`SRC_FREQ_RESET >> 16);
            freq_mid_q <= 8'(`SRC_FREQ_RESET >> 8);
            freq_q <= `SRC_FREQ_RESET;
        end else if (wr_q) begin
            if (wr_addr_q == `SRC_ADDR_FREQ_HI) freq_hi_q <= wr_data_q;
            if (wr_addr_q == `SRC_ADDR_FREQ_MID) freq_mid_q <= wr_data_q;
            if (wr_addr_q == `SRC_ADDR_FREQ_LO) freq_q <= {freq_hi_q, freq_mid_q, wr_data_q};
        end
    end

    assign CARRIER_FREQUENCY_WORD = freq_q;
    assign SDM_INTEGER = freq_q[23:`SRC_SDM_BITS];
    assign SDM_FRACTION = freq_q[`SRC_SDM_BITS-1:0];

    // ------------------------------------------------------------------------
    // Startup sequencer
    // ------------------------------------------------------------------------
    logic boot_q, tmr_start_q, tmr_done, synth_req, tx_req, sleep_mode;
    logic [`SRC_TMR_W-1:0] tmr_len_q;

    assign sleep_mode = (mode_q[2:0] == `SRC_MODE_SLEEP);
    assign tx_req = (mode_q[2:0] == `SRC_MODE_TX);
    assign synth_req = ~sleep_mode & (mode_q[`SRC_MODE_SEQ_OFF] ? mode_q[`SRC_MODE_MAN_SYNTH]
                                      : (mode_q[2:0] >= `SRC_MODE_SYNTH));

    src_timer u_timer (
        .clk(CLK_SYS),
        .rst(RST),
        .start(tmr_start_q),
        .len(tmr_len_q),
        .done(tmr_done)
    );

    // State walk; settle, coarse, fine and wake-up steps each have one timed wait
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_q <= ST_OSC;
            boot_q <= 1'b1;
            tmr_start_q <= 1'b0;
            tmr_len_q <= '0;
            osc_ok_q <= 1'b0;
            coarse_ok_q <= 1'b0;
        end else begin
            boot_q <= 1'b0;
            tmr_start_q <= 1'b0;
            case (state_q)
                ST_OSC: begin
                    if (boot_q) begin
                        tmr_start_q <= 1'b1;
                        tmr_len_q <= `SRC_TMR_W'(OSC_SETTLE_CYC);
                    end else if (tmr_done) begin
                        osc_ok_q <= 1'b1;
                        state_q <= ST_COARSE;
                        tmr_start_q <= 1'b1;
                        tmr_len_q <= `SRC_TMR_W'(COARSE_CYC);
                    end
                end
                ST_COARSE: if (tmr_done) begin
                    coarse_ok_q <= 1'b1;
                    state_q <= ST_STBY;
                end
                ST_STBY: if (synth_req) begin
                    state_q <= ST_FINE;
                    tmr_start_q <= 1'b1;
                    tmr_len_q <= `SRC_TMR_W'(FINE_CYC);
                end
                ST_FINE: begin
                    if (!synth_req) state_q <= ST_STBY;
                    else if (tmr_done) state_q <= ST_SYNTH;
                end
                ST_SYNTH: begin
                    if (!synth_req) begin
                        state_q <= ST_STBY;
                    end else if (tx_req) begin
                        state_q <= ST_TXWAKE;
                        tmr_start_q <= 1'b1;
                        tmr_len_q <= `SRC_TMR_W'(TX_WAKE_CYC);
                    end
                end
                ST_TXWAKE: begin
                    if (!tx_req || !synth_req) state_q <= ST_SYNTH;
                    else if (tmr_done) state_q <= ST_TX;
                end
                ST_TX: if (!tx_req || !synth_req) state_q <= ST_SYNTH;
                default: state_q <= ST_OSC;
            endcase
        end
    end

    // Status outputs for the analog synthesizer
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            SYNTH_ENABLE <= 1'b0;
            COARSE_CAL_ACTIVE <= 1'b0;
            FINE_CAL_ACTIVE <= 1'b0;
        end else begin
            SYNTH_ENABLE <= (state_q == ST_FINE) || (state_q == ST_SYNTH) ||
                            (state_q == ST_TXWAKE) || (state_q == ST_TX);
            COARSE_CAL_ACTIVE <= (state_q == ST_COARSE);
            FINE_CAL_ACTIVE <= (state_q == ST_FINE);
        end
    end

    // ------------------------------------------------------------------------
    // Bit clock: rises as the transmitter wake-up wait ends
    // ------------------------------------------------------------------------
    logic [`SRC_TMR_W-1:0] bclk_cnt_q;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            BIT_CLOCK_OUTPUT <= 1'b0;
            bclk_cnt_q <= '0;
        end else if (state_q == ST_TXWAKE && tmr_done && tx_req && synth_req) begin
            BIT_CLOCK_OUTPUT <= 1'b1;
            bclk_cnt_q <= '0;
        end else if (state_q == ST_TX) begin
            if (bclk_cnt_q == `SRC_TMR_W'(BIT_HALF_CYC - 1)) begin
                bclk_cnt_q <= '0;
                BIT_CLOCK_OUTPUT <= ~BIT_CLOCK_OUTPUT;
            end else begin
                bclk_cnt_q <= bclk_cnt_q + `SRC_TMR_W'(1);
            end
        end else begin
            BIT_CLOCK_OUTPUT <= 1'b0;
            bclk_cnt_q <= '0;
        end
    end

    // ------------------------------------------------------------------------
    // Reference clock output divider on auxiliary pin five
    // ------------------------------------------------------------------------
    logic [6:0] div_q;
    logic [2:0] clk_sel;

    assign clk_sel = pin_map2_q[2:0];

    // Half period is 2^select cycles; silent before oscillator settles or in sleep
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            div_q <= 7'h00;
            AUXILIARY_PIN_FIVE <= 1'b0;
        end else if (!osc_ok_q || sleep_mode || clk_sel == `SRC_CLKSEL_OFF) begin
            div_q <= 7'h00;
            AUXILIARY_PIN_FIVE <= 1'b0;
        end else if (div_q >= (7'(1) << clk_sel) - 7'h01) begin
            div_q <= 7'h00;
            AUXILIARY_PIN_FIVE <= ~AUXILIARY_PIN_FIVE;
        end else begin
            div_q <= div_q + 7'h01;
        end
    end

endmodule

// *** rtl/src_regs.svh ***
/*
 * Register offsets, field positions, reset values and timing figures of the
 * reference clock and synthesizer control block.
 * Assumes a 100 MHz system clock taken from the crystal oscillator.
 */
`ifndef SRC_REGS_SVH
`define SRC_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (7-bit serial addresses)
// ----------------------------------------------------------------------------
`define SRC_ADDR_MODE 7'h01
`define SRC_ADDR_FREQ_HI 7'h07
`define SRC_ADDR_FREQ_MID 7'h08
`define SRC_ADDR_FREQ_LO 7'h09
`define SRC_ADDR_PIN_MAP2 7'h0A
`define SRC_ADDR_STATUS 7'h0B

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define SRC_MODE_SEQ_OFF 7
`define SRC_MODE_MAN_SYNTH 6
`define SRC_MODE_SLEEP 3'h0
`define SRC_MODE_STANDBY 3'h1
`define SRC_MODE_SYNTH 3'h2
`define SRC_MODE_TX 3'h3
`define SRC_MODE_RESET 8'h01
`define SRC_PIN_MAP2_RESET 8'h00
`define SRC_CLKSEL_OFF 3'h7
`define SRC_FREQ_RESET 24'h00_0000
`define SRC_SDM_BITS 19

// ----------------------------------------------------------------------------
// Timing figures
// ----------------------------------------------------------------------------
`define SRC_CLK_PERIOD_NS 10
`define SRC_OSC_SETTLE_US 500
`define SRC_TX_WAKE_US 120
`define SRC_BIT_RATE_BPS 4800
`define SRC_COARSE_CAL_US 20
`define SRC_FINE_CAL_US 10
`define SRC_TMR_W 17

`endif

// *** rtl/src_pkg.sv ***
/*
 * Types shared by the reference clock and synthesizer control block.
 * Assumes src_regs.svh supplies all numeric constants.
 */
package src_pkg;

    // ------------------------------------------------------------------------
    // Startup and synthesizer sequencer states
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OSC,
        ST_COARSE,
        ST_STBY,
        ST_FINE,
        ST_SYNTH,
        ST_TXWAKE,
        ST_TX
    } src_state_e;

endpackage

// *** rtl/src_timer.sv ***
/*
 * One-shot down counter used for settle, calibration and wake-up waits.
 * Assumes start is a one-cycle pulse and len is at least one.
 */
`timescale 1ns/1ps
`include "src_regs.svh"

module src_timer
    import src_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [`SRC_TMR_W-1:0] len,
    output logic done
);

    logic [`SRC_TMR_W-1:0] cnt_q;
    logic busy_q;

    // Count down; a new start restarts the wait
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cnt_q <= len;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (cnt_q <= `SRC_TMR_W'(1)) begin
                    busy_q <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - `SRC_TMR_W'(1);
                end
            end
        end
    end

endmodule

// *** tb/src_host_model.sv ***
/*
 * Host model: serial register master, mode 0, MSB first, one data byte.
 * Assumes each clock phase lasts six system clock cycles.
 */
`timescale 1ns/1ps

module src_host_model (
    input wire logic clk,
    output logic nss_n,
    output logic sck,
    output logic mosi,
    input wire logic miso
);
    // Idle select high, clock still
    initial begin
        nss_n = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
    end

    // Wait one clock phase, then step off the edge
    task automatic half();
        repeat (6) @(posedge clk);
        #1;
    endtask

    // Shift one byte out and one in
    task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            half();
            rx[i] = miso;
            sck = 1'b1;
            half();
            sck = 1'b0;
        end
    endtask

    // Address byte then one data byte; released data line inverts
    task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [7:0] junk;
        @(posedge clk);
        #1;
        nss_n = 1'b0;
        shift({wr, a}, junk);
        shift(d, q);
        repeat (8) @(posedge clk);
        #1;
        nss_n = 1'b1;
        mosi = ~mosi;
        half();
    endtask
endmodule

// *** tb/src_clock_control_chk.sv ***
/*
 * Port checker of the clock control block.
 * Assumes it is bound to src_clock_control with its count parameters.
 */
`timescale 1ns/1ps
`include "src_regs.svh"

module src_cc_chk #(
    parameter int OSC_SETTLE_CYC = 50,
    parameter int BIT_HALF_CYC = 4
)(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic SPI_NSS_N,
    input wire logic AUXILIARY_PIN_FIVE,
    input wire logic BIT_CLOCK_OUTPUT,
    input wire logic SYNTH_ENABLE,
    input wire logic COARSE_CAL_ACTIVE,
    input wire logic FINE_CAL_ACTIVE,
    input wire logic [23:0] CARRIER_FREQUENCY_WORD,
    input wire logic [4:0] SDM_INTEGER,
    input wire logic [`SRC_SDM_BITS-1:0] SDM_FRACTION
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    localparam int COARSE_CYC = `SRC_COARSE_CAL_US * 1000 / `SRC_CLK_PERIOD_NS;
    localparam int FINE_CYC = `SRC_FINE_CAL_US * 1000 / `SRC_CLK_PERIOD_NS;
    localparam int CAL_SLACK = 5;

    logic [31:0] cyc_q;
    logic [31:0] hold_q;
    logic bck_q;
    logic [31:0] ccal_q;
    logic [31:0] fcal_q;

    // Length of the present coarse and fine calibration runs
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ccal_q <= 32'h0000_0000;
            fcal_q <= 32'h0000_0000;
        end else begin
            ccal_q <= COARSE_CAL_ACTIVE ? ccal_q + 32'h0000_0001 : 32'h0000_0000;
            fcal_q <= FINE_CAL_ACTIVE ? fcal_q + 32'h0000_0001 : 32'h0000_0000;
        end
    end

    // Cycles since reset and length of the present bit clock level
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            cyc_q <= 32'h0000_0000;
            hold_q <= 32'h0000_0000;
            bck_q <= 1'b0;
        end else begin
            cyc_q <= cyc_q + 32'h0000_0001;
            hold_q <= (BIT_CLOCK_OUTPUT != bck_q) ? 32'h0000_0001 : hold_q + 32'h0000_0001;
            bck_q <= BIT_CLOCK_OUTPUT;
        end
    end

    chk_aux_silent: assert property (cyc_q < OSC_SETTLE_CYC |-> !AUXILIARY_PIN_FIVE)
        else $error("clock output active before settle");
    chk_coarse_start: assert property (cyc_q == OSC_SETTLE_CYC + 8 |-> COARSE_CAL_ACTIVE)
        else $error("coarse calibration not started");
    chk_coarse_early: assert property ($rose(COARSE_CAL_ACTIVE) |-> cyc_q >= OSC_SETTLE_CYC)
        else $error("coarse calibration before settle");
    chk_coarse_len: assert property ($fell(COARSE_CAL_ACTIVE) |->
        ccal_q >= COARSE_CYC - CAL_SLACK && ccal_q <= COARSE_CYC + CAL_SLACK)
        else $error("coarse calibration length wrong");
    chk_fine_len: assert property ($fell(FINE_CAL_ACTIVE) |->
        fcal_q >= FINE_CYC - CAL_SLACK && fcal_q <= FINE_CYC + CAL_SLACK)
        else $error("fine calibration length wrong");
    chk_fine_first: assert property ($rose(SYNTH_ENABLE) |-> FINE_CAL_ACTIVE)
        else $error("synthesizer on without fine calibration");
    chk_synth_stable: assert property (COARSE_CAL_ACTIVE |-> !SYNTH_ENABLE)
        else $error("synthesizer on before oscillator ready");
    // A high level cut short by leaving transmit for standby is followed by the synthesizer turning off
    chk_bit_half: assert property (bck_q && !BIT_CLOCK_OUTPUT && SYNTH_ENABLE |=>
        !SYNTH_ENABLE || $past(hold_q) == BIT_HALF_CYC)
        else $error("bit clock high time wrong");
    chk_bit_max: assert property (BIT_CLOCK_OUTPUT && bck_q |-> hold_q < BIT_HALF_CYC)
        else $error("bit clock high level too long");
    chk_word_commit: assert property ($changed(CARRIER_FREQUENCY_WORD) |-> !SPI_NSS_N)
        else $error("carrier word changed outside access");
    chk_sdm_split: assert property ({SDM_INTEGER, SDM_FRACTION} == CARRIER_FREQUENCY_WORD)
        else $error("modulator word differs from carrier word");

    // Main scenarios seen
    cov_coarse: cover property ($fell(COARSE_CAL_ACTIVE));
    cov_bit: cover property ($rose(BIT_CLOCK_OUTPUT));
    cov_word: cover property ($changed(CARRIER_FREQUENCY_WORD));
endmodule

bind src_clock_control src_cc_chk #(.OSC_SETTLE_CYC(OSC_SETTLE_CYC), .BIT_HALF_CYC(BIT_HALF_CYC)) chk_u (
    .CLK_SYS(CLK_SYS), .RST(RST), .SPI_NSS_N(SPI_NSS_N), .AUXILIARY_PIN_FIVE(AUXILIARY_PIN_FIVE),
    .BIT_CLOCK_OUTPUT(BIT_CLOCK_OUTPUT), .SYNTH_ENABLE(SYNTH_ENABLE), .COARSE_CAL_ACTIVE(COARSE_CAL_ACTIVE),
    .FINE_CAL_ACTIVE(FINE_CAL_ACTIVE), .CARRIER_FREQUENCY_WORD(CARRIER_FREQUENCY_WORD),
    .SDM_INTEGER(SDM_INTEGER), .SDM_FRACTION(SDM_FRACTION));

// *** tb/src_clock_control_bench.sv ***
/*
 * Self-checking bench of the clock control block.
 * Assumes the host model and checker files are compiled before it.
 */
`timescale 1ns/1ps
`include "src_regs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected t=%0t got %h exp %h", $time, (g), (e)); end end

module src_clock_control_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic nss_n, sck, mosi, miso_d, miso_oe, aux, bck, syn, cca, fca;
    logic [23:0] cw;
    logic [4:0] sint;
    logic [`SRC_SDM_BITS-1:0] sfrac;
    logic [7:0] q;
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;
    int n;
    wire miso_w = miso_oe ? miso_d : 1'b1;

    always #5 clk = ~clk;

    src_host_model host_u (.clk(clk), .nss_n(nss_n), .sck(sck), .mosi(mosi), .miso(miso_w));

    src_clock_control #(.OSC_SETTLE_CYC(50), .TX_WAKE_CYC(40), .BIT_HALF_CYC(4)) dut_u (
        .CLK_SYS(clk), .RST(rst), .SPI_NSS_N(nss_n), .SPI_SCK(sck), .SPI_MOSI(mosi),
        .SPI_MISO(miso_d), .SPI_MISO_OE(miso_oe), .AUXILIARY_PIN_FIVE(aux), .BIT_CLOCK_OUTPUT(bck),
        .SYNTH_ENABLE(syn), .COARSE_CAL_ACTIVE(cca), .FINE_CAL_ACTIVE(fca),
        .CARRIER_FREQUENCY_WORD(cw), .SDM_INTEGER(sint), .SDM_FRACTION(sfrac));

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] x;
        host_u.access(1'b1, a, d, x);
    endtask

    task automatic rd(input logic [6:0] a);
        host_u.access(1'b0, a, 8'h00, q);
    endtask

    // Wait until sig equals v, at most lim cycles; n holds the wait
    task automatic wait_on(ref logic sig, input logic v, input int lim);
        n = 0;
        while (n < lim && sig !== v) begin
            tick();
            n++;
        end
    endtask

    // Second full level of the clock output; 300 means it stood still
    task automatic aux_half();
        logic v;
        for (int k = 0; k < 3; k++) begin
            v = aux;
            wait_on(aux, ~v, 300);
        end
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_startup();
        repeat (5) tick();
        rst = 1'b0;
        for (int i = 0; i < 48; i++) begin
            tick();
            `CHK(aux, 1'b0)
        end
        wait_on(cca, 1'b1, 20);
        `CHK(cca, 1'b1)
        wait_on(cca, 1'b0, 2100);
        `CHK(syn, 1'b0)
        aux_half();
        `CHK(n, 1)
        $display("test startup done");
    endtask

    task automatic t_regs();
        `CHK(cw, 24'h00_0000)
        rd(7'h01);
        `CHK(q, 8'h01)
        rd(7'h0A);
        `CHK(q, 8'h00)
        wr(7'h20, 8'h5A);
        rd(7'h20);
        `CHK(q, 8'h00)
        rd(7'h0B);
        `CHK(q, 8'h03)
        $display("test registers done");
    endtask

    task automatic t_freq();
        logic [23:0] e;
        e = 24'hAB_CDEF;
        wr(7'h07, e[23:16]);
        wr(7'h08, e[15:8]);
        `CHK(cw, 24'h00_0000)
        rd(7'h07);
        `CHK(q, e[23:16])
        wr(7'h09, e[7:0]);
        `CHK(cw, e)
        `CHK(sint, e[23:19])
        `CHK(sfrac, e[18:0])
        wr(7'h09, 8'h12);
        `CHK(cw, 24'hAB_CD12)
        $display("test carrier word done");
    endtask

    task automatic t_clksel();
        for (int s = 0; s < 7; s++) begin
            wr(7'h0A, 8'(s));
            aux_half();
            `CHK(n, 1 << s)
        end
        wr(7'h0A, 8'h07);
        aux_half();
        `CHK(n, 300)
        `CHK(aux, 1'b0)
        wr(7'h0A, 8'h00);
        wr(7'h01, 8'h00);
        aux_half();
        `CHK(aux, 1'b0)
        `CHK(n, 300)
        wr(7'h01, 8'h01);
        aux_half();
        `CHK(n, 1)
        $display("test clock select done");
    endtask

    task automatic t_tx();
        wr(7'h01, 8'h02);
        `CHK(syn, 1'b1)
        `CHK(fca, 1'b1)
        wait_on(fca, 1'b0, 1100);
        `CHK(syn, 1'b1)
        wr(7'h01, 8'h03);
        wait_on(bck, 1'b1, 200);
        `CHK(n >= 20 && n <= 40, 1'b1)
        wait_on(bck, 1'b0, 20);
        `CHK(n, 4)
        wr(7'h01, 8'h01);
        `CHK(syn, 1'b0)
        wr(7'h01, 8'hC1);
        `CHK(syn, 1'b1)
        `CHK(fca, 1'b1)
        wait_on(fca, 1'b0, 1100);
        rd(7'h0B);
        `CHK(q, 8'h07)
        wr(7'h01, 8'h81);
        `CHK(syn, 1'b0)
        $display("test transmit done");
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            mismatches++;
            end_sim();
        end
    end

    // Main sequence
    initial begin
        t_startup();
        t_regs();
        t_freq();
        t_clksel();
        t_tx();
        end_sim();
    end
endmodule
